//--- rtl/rcq_pkg.sv
// Package for the render control and label query register bank.
// Assumes a 32-bit AXI4-Lite bus with 24-bit byte addresses.
package rcq_pkg;

   // Bus geometry
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // Register byte addresses
   localparam logic [23:0] OFF_RENDER_STYLE = 24'h102410;
   localparam logic [23:0] OFF_TARGET_LINE  = 24'h102414;
   localparam logic [23:0] OFF_LINE_CAPTURE = 24'h102418;
   localparam logic [23:0] OFF_LIST_SWAP    = 24'h102450;
   localparam logic [23:0] OFF_PROBE_X      = 24'h102470;
   localparam logic [23:0] OFF_PROBE_Y      = 24'h102474;
   localparam logic [23:0] OFF_LABEL_RESULT = 24'h102478;

   // Field widths
   localparam int LINE_W  = 9;
   localparam int COORD_W = 9;
   localparam int LABEL_W = 8;
   localparam int SWAP_W  = 2;
   localparam int PIX_W   = 32;

   // Reset values
   localparam logic            RST_RENDER_STYLE = 1'h0;
   localparam logic [8:0]      RST_TARGET_LINE  = 9'h000;
   localparam logic            RST_LINE_CAPTURE = 1'h0;
   localparam logic [1:0]      RST_LIST_SWAP    = 2'h0;
   localparam logic [8:0]      RST_PROBE        = 9'h000;
   localparam logic [7:0]      RST_LABEL        = 8'h00;

   // Swap field codes
   localparam logic [1:0] SWAP_IDLE  = 2'h0;
   localparam logic [1:0] SWAP_LINE  = 2'h1;
   localparam logic [1:0] SWAP_FRAME = 2'h2;

   // Render style codes
   localparam logic STYLE_NORMAL = 1'h0;
   localparam logic STYLE_SINGLE = 1'h1;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Line capture sequencer
   typedef enum logic [1:0] {
      CAP_IDLE,
      CAP_ARMED,
      CAP_ACTIVE
   } rcq_cap_e;

   // Whole state of the register bank
   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                aw_held;
      logic                w_held;
      logic [ADDR_W-1:0]   aw_addr;
      logic [DATA_W-1:0]   w_data;
      logic [STRB_W-1:0]   w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
      logic [1:0]          rresp;
      logic                render_style;
      logic [LINE_W-1:0]   target_line;
      logic                capture_bit;
      logic [SWAP_W-1:0]   list_swap;
      logic [COORD_W-1:0]  probe_x;
      logic [COORD_W-1:0]  probe_y;
      logic [LABEL_W-1:0]  label;
      rcq_cap_e            cap_state;
      logic [LINE_W-1:0]   cap_addr;
      logic                cap_we;
      logic [PIX_W-1:0]    cap_wdata;
      logic [LINE_W-1:0]   cap_waddr;
      logic                swap_now;
      logic                render_single;
      logic [LINE_W-1:0]   render_line;
   } rcq_state_s;

endpackage

//--- rtl/rcq_regs.sv
// Render control and label query register bank with AXI4-Lite slave.
// Assumes the engine gives scan-out pulses, a pixel stream and the label
// found at the probe coordinate; all inputs synchronous to CLK.
//
// Behaviour
// - Capture bit stores current line into memory; code waits for the next line start and stores that line
// - Target line bits 0-8 name rendered line
// - Target line ignored in normal rendering
// - Target line accepts 0 through 511
// - Swap 01 takes effect after current line
// - Swap 10 takes effect after current frame
// - Swap reads zero only when buffer safe
// - Label result bits 0-7 from probe point
// - Label result is read-only to host
// - Label follows probe point, not touch
// - Probe Y: 9 bits, host written, reset zero
// - Probe X: 9 bits, host written, reset zero
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module rcq_regs (
   input  wire logic                          CLK,
   input  wire logic                          RSTN,
   // AXI4-Lite write address
   input  wire logic                          AWVALID,
   output logic                               AWREADY,
   input  wire logic [rcq_pkg::ADDR_W-1:0]    AWADDR,
   input  wire logic [2:0]                    AWPROT,
   // AXI4-Lite write data
   input  wire logic                          WVALID,
   output logic                               WREADY,
   input  wire logic [rcq_pkg::DATA_W-1:0]    WDATA,
   input  wire logic [rcq_pkg::STRB_W-1:0]    WSTRB,
   // AXI4-Lite write response
   output logic                               BVALID,
   input  wire logic                          BREADY,
   output logic [1:0]                         BRESP,
   // AXI4-Lite read address
   input  wire logic                          ARVALID,
   output logic                               ARREADY,
   input  wire logic [rcq_pkg::ADDR_W-1:0]    ARADDR,
   input  wire logic [2:0]                    ARPROT,
   // AXI4-Lite read data
   output logic                               RVALID,
   input  wire logic                          RREADY,
   output logic [rcq_pkg::DATA_W-1:0]         RDATA,
   output logic [1:0]                         RRESP,
   // Scan-out timing from the engine
   input  wire logic                          LINE_START,
   input  wire logic                          LINE_END,
   input  wire logic                          FRAME_END,
   // Pixel stream of the line being scanned out
   input  wire logic                          PIX_VALID,
   input  wire logic [rcq_pkg::PIX_W-1:0]     PIX_DATA,
   // Label found by the engine at the probe point
   input  wire logic [rcq_pkg::LABEL_W-1:0]   PROBE_LABEL,
   // Control to the engine
   output logic                               SWAP_NOW,
   output logic                               RENDER_SINGLE,
   output logic [rcq_pkg::LINE_W-1:0]         RENDER_LINE,
   output logic [rcq_pkg::COORD_W-1:0]        PROBE_X,
   output logic [rcq_pkg::COORD_W-1:0]        PROBE_Y,
   // Line capture memory write port
   output logic                               CAP_WE,
   output logic [rcq_pkg::LINE_W-1:0]         CAP_ADDR,
   output logic [rcq_pkg::PIX_W-1:0]          CAP_WDATA
);

   rcq_pkg::rcq_state_s st;
   rcq_pkg::rcq_state_s next_st;

   // Merge write data into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // True when the address names a register of the bank
   function automatic logic mapped(input logic [rcq_pkg::ADDR_W-1:0] a);
      return (a == rcq_pkg::OFF_RENDER_STYLE) || (a == rcq_pkg::OFF_TARGET_LINE)
          || (a == rcq_pkg::OFF_LINE_CAPTURE) || (a == rcq_pkg::OFF_LIST_SWAP)
          || (a == rcq_pkg::OFF_PROBE_X)      || (a == rcq_pkg::OFF_PROBE_Y)
          || (a == rcq_pkg::OFF_LABEL_RESULT);
   endfunction

   // Answer code for an access: refused outside the bank
   function automatic logic [1:0] resp_for(input logic [rcq_pkg::ADDR_W-1:0] a);
      return mapped(a) ? rcq_pkg::RESP_OKAY : rcq_pkg::RESP_SLVERR;
   endfunction

   // Read-back value; reserved bits read zero
   function automatic logic [31:0] readback(input logic [rcq_pkg::ADDR_W-1:0] a,
                                            input rcq_pkg::rcq_state_s s);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         rcq_pkg::OFF_RENDER_STYLE: v[0] = s.render_style;
         rcq_pkg::OFF_TARGET_LINE:  v[rcq_pkg::LINE_W-1:0] = s.target_line;
         rcq_pkg::OFF_LINE_CAPTURE: v[0] = s.capture_bit;
         rcq_pkg::OFF_LIST_SWAP:    v[rcq_pkg::SWAP_W-1:0] = s.list_swap;
         rcq_pkg::OFF_PROBE_X:      v[rcq_pkg::COORD_W-1:0] = s.probe_x;
         rcq_pkg::OFF_PROBE_Y:      v[rcq_pkg::COORD_W-1:0] = s.probe_y;
         rcq_pkg::OFF_LABEL_RESULT: v[rcq_pkg::LABEL_W-1:0] = s.label;
         default:                   v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Next-state logic for bus, registers and capture
   always_comb begin
      logic                       do_write;
      logic [rcq_pkg::ADDR_W-1:0] wa;
      logic [31:0]                wd;
      logic [3:0]                 ws;
      logic [31:0]                merged;
      logic                       cap_write;
      logic                       cap_clear;

      do_write  = 1'b0;
      wa        = st.aw_addr;
      wd        = st.w_data;
      ws        = st.w_strb;
      merged    = 32'h0000_0000;
      cap_write = 1'b0;
      cap_clear = 1'b0;
      next_st   = st;

      // Write address and data are taken in either order
      if (AWVALID && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = AWADDR;
         next_st.awready = 1'b0;
         wa              = AWADDR;
      end
      if (WVALID && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = WDATA;
         next_st.w_strb = WSTRB;
         next_st.wready = 1'b0;
         wd             = WDATA;
         ws             = WSTRB;
      end

      // Commit once both halves are here and no response waits
      if (next_st.aw_held && next_st.w_held && !st.bvalid) begin
         do_write        = 1'b1;
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = resp_for(wa);
      end

      // Write response handshake reopens both channels
      if (st.bvalid && BREADY) begin
         next_st.bvalid  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end

      // Read channel: one read in flight
      if (ARVALID && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = readback(ARADDR, st);
         next_st.rresp   = resp_for(ARADDR);
      end

      // Read answer taken reopens the address channel
      if (st.rvalid && RREADY) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end

      // Pending swap retires at the chosen scan-out boundary
      next_st.swap_now = 1'b0;
      if ((st.list_swap == rcq_pkg::SWAP_LINE) && LINE_END) begin
         next_st.list_swap = rcq_pkg::SWAP_IDLE;
         next_st.swap_now  = 1'b1;
      end
      if ((st.list_swap == rcq_pkg::SWAP_FRAME) && FRAME_END) begin
         next_st.list_swap = rcq_pkg::SWAP_IDLE;
         next_st.swap_now  = 1'b1;
      end

      // Capture sequencer: wait for a line start, store, stop at line end
      next_st.cap_we = 1'b0;
      unique case (st.cap_state)
         rcq_pkg::CAP_IDLE: begin
            if (st.capture_bit) begin
               next_st.cap_state = rcq_pkg::CAP_ARMED;
            end
         end
         rcq_pkg::CAP_ARMED: begin
            if (LINE_START) begin
               next_st.cap_state = rcq_pkg::CAP_ACTIVE;
               next_st.cap_addr  = '0;
            end
         end
         rcq_pkg::CAP_ACTIVE: begin
            if (PIX_VALID) begin
               next_st.cap_we    = 1'b1;
               next_st.cap_wdata = PIX_DATA;
               next_st.cap_waddr = st.cap_addr;
               next_st.cap_addr  = st.cap_addr + 9'h001;
            end
            if (LINE_END) begin
               next_st.cap_state = rcq_pkg::CAP_IDLE;
               cap_clear         = 1'b1;
            end
         end
         default: begin
            next_st.cap_state = rcq_pkg::CAP_IDLE;
         end
      endcase

      // Line end retires the capture request
      if (cap_clear) begin
         next_st.capture_bit = 1'b0;
      end

      // Register writes; a host write wins over a same-cycle clear
      if (do_write) begin
         unique case (wa)
            rcq_pkg::OFF_RENDER_STYLE: begin
               merged = merge({31'h0, st.render_style}, wd, ws);
               next_st.render_style = merged[0];
            end
            rcq_pkg::OFF_TARGET_LINE: begin
               merged = merge({23'h0, st.target_line}, wd, ws);
               next_st.target_line = merged[rcq_pkg::LINE_W-1:0];
            end
            rcq_pkg::OFF_LINE_CAPTURE: begin
               merged    = merge({31'h0, st.capture_bit}, wd, ws);
               cap_write = merged[0];
               if (cap_write) begin
                  next_st.capture_bit = 1'b1;
               end else if (st.cap_state == rcq_pkg::CAP_ARMED) begin
                  next_st.capture_bit = 1'b0;
                  next_st.cap_state   = rcq_pkg::CAP_IDLE;
               end
            end
            rcq_pkg::OFF_LIST_SWAP: begin
               merged = merge({30'h0, st.list_swap}, wd, ws);
               // Illegal codes are dropped, leaving the field as it was
               if ((merged[1:0] == rcq_pkg::SWAP_LINE)
                   || (merged[1:0] == rcq_pkg::SWAP_FRAME)) begin
                  next_st.list_swap = merged[1:0];
               end
            end
            rcq_pkg::OFF_PROBE_X: begin
               merged = merge({23'h0, st.probe_x}, wd, ws);
               next_st.probe_x = merged[rcq_pkg::COORD_W-1:0];
            end
            rcq_pkg::OFF_PROBE_Y: begin
               merged = merge({23'h0, st.probe_y}, wd, ws);
               next_st.probe_y = merged[rcq_pkg::COORD_W-1:0];
            end
            default: begin
               merged = 32'h0000_0000; // Label result is read-only
            end
         endcase
      end

      // Label tracks the engine's answer for the probe point only
      next_st.label = PROBE_LABEL;

      // Line select reaches the engine only in single-line style
      next_st.render_single = next_st.render_style;
      next_st.render_line   = (next_st.render_style == rcq_pkg::STYLE_SINGLE)
                              ? next_st.target_line : '0;
   end

   // State register with synchronous reset
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         // Bus channels open, no answer pending
         st.awready       <= 1'b1;
         st.wready        <= 1'b1;
         st.aw_held       <= 1'b0;
         st.w_held        <= 1'b0;
         st.aw_addr       <= '0;
         st.w_data        <= '0;
         st.w_strb        <= '0;
         st.bvalid        <= 1'b0;
         st.bresp         <= rcq_pkg::RESP_OKAY;
         st.arready       <= 1'b1;
         st.rvalid        <= 1'b0;
         st.rdata         <= '0;
         st.rresp         <= rcq_pkg::RESP_OKAY;
         // Host registers at their reset values
         st.render_style  <= rcq_pkg::RST_RENDER_STYLE;
         st.target_line   <= rcq_pkg::RST_TARGET_LINE;
         st.capture_bit   <= rcq_pkg::RST_LINE_CAPTURE;
         st.list_swap     <= rcq_pkg::RST_LIST_SWAP;
         st.probe_x       <= rcq_pkg::RST_PROBE;
         st.probe_y       <= rcq_pkg::RST_PROBE;
         st.label         <= rcq_pkg::RST_LABEL;
         // Engine control and capture side quiet
         st.cap_state     <= rcq_pkg::CAP_IDLE;
         st.cap_addr      <= '0;
         st.cap_we        <= 1'b0;
         st.cap_wdata     <= '0;
         st.cap_waddr     <= '0;
         st.swap_now      <= 1'b0;
         st.render_single <= rcq_pkg::STYLE_NORMAL;
         st.render_line   <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Bus handshake and answers straight from state flip-flops
   assign AWREADY       = st.awready;
   assign WREADY        = st.wready;
   assign BVALID        = st.bvalid;
   assign BRESP         = st.bresp;
   assign ARREADY       = st.arready;
   assign RVALID        = st.rvalid;
   assign RDATA         = st.rdata;
   assign RRESP         = st.rresp;

   // Engine control straight from state flip-flops
   assign SWAP_NOW      = st.swap_now;
   assign RENDER_SINGLE = st.render_single;
   assign RENDER_LINE   = st.render_line;
   assign PROBE_X       = st.probe_x;
   assign PROBE_Y       = st.probe_y;

   // Capture memory write port straight from state flip-flops
   assign CAP_WE        = st.cap_we;
   assign CAP_ADDR      = st.cap_waddr;
   assign CAP_WDATA     = st.cap_wdata;

endmodule // rcq_regs

//--- sim/rcq_regs_sva.sv
// Port checker for the render control register bank.
// Bound onto rcq_regs; one clock CLK, synchronous active-low RSTN.
`timescale 1ns/1ns
module rcq_regs_sva (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        ARVALID,
   input wire logic        ARREADY,
   input wire logic        BVALID,
   input wire logic        BREADY,
   input wire logic [1:0]  BRESP,
   input wire logic        RVALID,
   input wire logic        RREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0]  RRESP,
   input wire logic        LINE_END,
   input wire logic        FRAME_END,
   input wire logic        PIX_VALID,
   input wire logic [31:0] PIX_DATA,
   input wire logic        SWAP_NOW,
   input wire logic        RENDER_SINGLE,
   input wire logic [8:0]  RENDER_LINE,
   input wire logic        CAP_WE,
   input wire logic [8:0]  CAP_ADDR,
   input wire logic [31:0] CAP_WDATA
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // Bus answers stand until taken; read answers come on time
   a_bresp_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");
   a_rdata_stands: assert property (RVALID && !RREADY |=>
      RVALID && $stable({RRESP, RDATA}))
      else $error("read answer changed before taken");
   a_read_latency: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_read_busy: assert property (RVALID |-> !ARREADY)
      else $error("read address taken while busy");
   a_error_zero: assert property (RVALID && RRESP == rcq_pkg::RESP_SLVERR |-> RDATA == 32'h0)
      else $error("refused read carries data");
   // Engine control
   a_line_ignored: assert property (!RENDER_SINGLE |-> RENDER_LINE == 9'h000)
      else $error("line select used in normal style");
   a_swap_cause: assert property (SWAP_NOW |-> $past(LINE_END) || $past(FRAME_END))
      else $error("swap without scan-out boundary");
   a_swap_pulse: assert property (SWAP_NOW |=> !SWAP_NOW)
      else $error("swap pulse too long");
   // Line capture writes follow the pixel stream
   a_cap_source: assert property (CAP_WE |->
      $past(PIX_VALID) && CAP_WDATA == $past(PIX_DATA))
      else $error("capture write without matching pixel");
   a_cap_step: assert property (CAP_WE ##1 CAP_WE |->
      CAP_ADDR == 9'($past(CAP_ADDR) + 9'h1))
      else $error("capture address did not step");
   c_swap: cover property (SWAP_NOW);
   c_cap_run: cover property (CAP_WE ##1 CAP_WE);
   c_refused: cover property (RVALID && RREADY && RRESP == rcq_pkg::RESP_SLVERR);
endmodule // rcq_regs_sva

bind rcq_regs rcq_regs_sva u_sva (
   .CLK(CLK), .RSTN(RSTN), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
   .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
   .LINE_END(LINE_END), .FRAME_END(FRAME_END), .PIX_VALID(PIX_VALID), .PIX_DATA(PIX_DATA),
   .SWAP_NOW(SWAP_NOW), .RENDER_SINGLE(RENDER_SINGLE), .RENDER_LINE(RENDER_LINE),
   .CAP_WE(CAP_WE), .CAP_ADDR(CAP_ADDR), .CAP_WDATA(CAP_WDATA)
);

//--- sim/rcq_regs_tb_top.sv
// Self-checking bench for the render control register bank.
// Assumes rcq_pkg, rcq_regs and the bound checker are compiled before it.
`timescale 1ns/1ns
module rcq_regs_tb_top;
   localparam logic [1:0] okay = rcq_pkg::RESP_OKAY;
   localparam logic [1:0] err  = rcq_pkg::RESP_SLVERR;
   logic        CLK = '0, RSTN = '0, AWVALID = '0, WVALID = '0, BREADY = '0;
   logic        ARVALID = '0, RREADY = '0, LINE_START = '0, LINE_END = '0;
   logic        FRAME_END = '0, PIX_VALID = '0;
   logic [23:0] AWADDR = '0, ARADDR = '0;
   logic [31:0] WDATA = '0, PIX_DATA = '0;
   logic [3:0]  WSTRB = '0;
   logic [3:0]  strb = 4'hf;
   logic [2:0]  AWPROT = '0, ARPROT = '0;
   logic [7:0]  PROBE_LABEL = '0;
   wire logic   AWREADY, WREADY, BVALID, ARREADY, RVALID, SWAP_NOW, RENDER_SINGLE, CAP_WE;
   wire logic [1:0]  BRESP, RRESP;
   wire logic [31:0] RDATA, CAP_WDATA;
   wire logic [8:0]  RENDER_LINE, PROBE_X, PROBE_Y, CAP_ADDR;
   int          error_cnt = 0, checks = 0, swaps = 0;
   logic [31:0] rng = 32'h0000004b;
   logic [34:0] busq[$];
   logic [40:0] capq[$];
   logic [23:0] regs[7] = '{rcq_pkg::OFF_RENDER_STYLE, rcq_pkg::OFF_TARGET_LINE,
      rcq_pkg::OFF_LINE_CAPTURE, rcq_pkg::OFF_LIST_SWAP, rcq_pkg::OFF_PROBE_X,
      rcq_pkg::OFF_PROBE_Y, rcq_pkg::OFF_LABEL_RESULT};

   rcq_regs DUT (
      .CLK(CLK), .RSTN(RSTN),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(AWPROT),
      .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(ARPROT),
      .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
      .LINE_START(LINE_START), .LINE_END(LINE_END), .FRAME_END(FRAME_END),
      .PIX_VALID(PIX_VALID), .PIX_DATA(PIX_DATA), .PROBE_LABEL(PROBE_LABEL),
      .SWAP_NOW(SWAP_NOW), .RENDER_SINGLE(RENDER_SINGLE), .RENDER_LINE(RENDER_LINE),
      .PROBE_X(PROBE_X), .PROBE_Y(PROBE_Y),
      .CAP_WE(CAP_WE), .CAP_ADDR(CAP_ADDR), .CAP_WDATA(CAP_WDATA)
   );

   // Clock of 40 ns period
   always #20 CLK = ~CLK;

   // Engine stand-in: label derived from the probe point
   always @(posedge CLK) PROBE_LABEL <= PROBE_X[7:0] ^ PROBE_Y[8:1];

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("Errors %0d, checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic hang();
      error_cnt++;
      $display("unexpected at %0t: bus answer missing", $time);
      summarize();
   endtask

   // Write one word; response ready after a one-cycle stall
   task automatic wr(input logic [23:0] a, input logic [31:0] d, input logic [1:0] r);
      busq.push_back({1'h0, r, 32'h0});
      @(posedge CLK);
      AWVALID <= '1;
      AWADDR <= a;
      WVALID <= '1;
      WDATA <= d;
      WSTRB <= strb;
      for (int i = 0; i < 20; i++) begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= '0;
         if (WREADY) WVALID <= '0;
         if (i == 1) BREADY <= '1;
         if (BVALID && BREADY) begin
            BREADY <= '0;
            return;
         end
      end
      hang();
   endtask

   // Read one word and note the expected answer
   task automatic rd(input logic [23:0] a, input logic [31:0] d, input logic [1:0] r);
      busq.push_back({1'h1, r, d});
      @(posedge CLK);
      ARVALID <= '1;
      ARADDR <= a;
      for (int i = 0; i < 20; i++) begin
         @(posedge CLK);
         if (ARREADY) ARVALID <= '0;
         if (i == 1) RREADY <= '1;
         if (RVALID && RREADY) begin
            RREADY <= '0;
            return;
         end
      end
      hang();
   endtask

   // Scan-out event: 0 line start, 1 line end, 2 frame end
   task automatic ev(input int k);
      @(posedge CLK);
      PIX_VALID <= '0;
      LINE_START <= (k == 0);
      LINE_END <= (k == 1);
      FRAME_END <= (k == 2);
      @(posedge CLK);
      LINE_START <= '0;
      LINE_END <= '0;
      FRAME_END <= '0;
   endtask

   // One pixel; kept ones are expected in capture memory
   task automatic pix(input logic [8:0] n, input bit keep);
      logic [31:0] v;
      v = xs();
      @(posedge CLK);
      PIX_VALID <= '1;
      PIX_DATA <= v;
      if (keep) capq.push_back({n, v});
   endtask

   // Watcher: compares every answer with the oldest note
   always @(posedge CLK) begin
      if (BVALID && BREADY) chk({1'h0, BRESP, 32'h0}, busq.pop_front());
      if (RVALID && RREADY) chk({1'h1, RRESP, RDATA}, busq.pop_front());
      if (CAP_WE) chk({CAP_ADDR, CAP_WDATA}, capq.pop_front());
      if (SWAP_NOW) swaps <= swaps + 1;
   end

   initial begin
      logic [31:0] v;
      repeat (10) @(posedge CLK);
      RSTN <= '1;
      // Reset values, then an unmapped place
      foreach (regs[i]) rd(regs[i], 32'h0, okay);
      rd(24'h10241c, 32'h0, err);
      wr(24'h10241c, 32'h1, err);
      // Line select ignored in normal style, used in single-line style
      wr(rcq_pkg::OFF_TARGET_LINE, 32'hffffffff, okay);
      rd(rcq_pkg::OFF_TARGET_LINE, 32'h1ff, okay);
      chk({RENDER_SINGLE, RENDER_LINE}, 64'h0);
      wr(rcq_pkg::OFF_RENDER_STYLE, 32'h1, okay);
      repeat (2) @(posedge CLK);
      chk({RENDER_SINGLE, RENDER_LINE}, 64'h3ff);
      wr(rcq_pkg::OFF_TARGET_LINE, 32'h0, okay);
      repeat (2) @(posedge CLK);
      chk({RENDER_SINGLE, RENDER_LINE}, 64'h200);
      wr(rcq_pkg::OFF_RENDER_STYLE, 32'h0, okay);
      rd(rcq_pkg::OFF_RENDER_STYLE, 32'h0, okay);
      // Byte strobes: only the second byte of the line select lands
      strb = 4'h2;
      wr(rcq_pkg::OFF_TARGET_LINE, 32'h1ff, okay);
      strb = 4'hf;
      rd(rcq_pkg::OFF_TARGET_LINE, 32'h100, okay);
      chk({RENDER_SINGLE, RENDER_LINE}, 64'h0);
      // Swap codes: illegal writes ignored, wrong boundary keeps it pending
      for (int c = 1; c <= 2; c++) begin
         wr(rcq_pkg::OFF_LIST_SWAP, 32'(c), okay);
         wr(rcq_pkg::OFF_LIST_SWAP, (c == 1) ? 32'h0 : 32'h3, okay);
         ev(0);
         if (c == 2) ev(1);
         rd(rcq_pkg::OFF_LIST_SWAP, 32'(c), okay);
         ev(c);
         rd(rcq_pkg::OFF_LIST_SWAP, 32'h0, okay);
         chk(swaps, c);
      end
      // Line capture: pixel while armed dropped, then four stored
      wr(rcq_pkg::OFF_LINE_CAPTURE, 32'h1, okay);
      rd(rcq_pkg::OFF_LINE_CAPTURE, 32'h1, okay);
      pix(9'h0, 1'b0);
      ev(0);
      for (int n = 0; n < 4; n++) pix(9'(n), 1'b1);
      ev(1);
      repeat (2) @(posedge CLK);
      chk(capq.size(), 0);
      rd(rcq_pkg::OFF_LINE_CAPTURE, 32'h0, okay);
      // Clearing the trigger before the line starts cancels the capture
      wr(rcq_pkg::OFF_LINE_CAPTURE, 32'h1, okay);
      wr(rcq_pkg::OFF_LINE_CAPTURE, 32'h0, okay);
      rd(rcq_pkg::OFF_LINE_CAPTURE, 32'h0, okay);
      ev(0);
      pix(9'h0, 1'b0);
      ev(1);
      // Probe point and label, label register ignores writes
      for (int i = 0; i < 3; i++) begin
         v = xs();
         wr(rcq_pkg::OFF_PROBE_X, v, okay);
         wr(rcq_pkg::OFF_PROBE_Y, ~v, okay);
         rd(rcq_pkg::OFF_PROBE_X, {23'h0, v[8:0]}, okay);
         rd(rcq_pkg::OFF_PROBE_Y, {23'h0, ~v[8:0]}, okay);
         wr(rcq_pkg::OFF_LABEL_RESULT, 32'hff, okay);
         rd(rcq_pkg::OFF_LABEL_RESULT, {24'h0, v[7:0] ^ ~v[8:1]}, okay);
      end
      repeat (3) @(posedge CLK);
      summarize();
   end
endmodule // rcq_regs_tb_top
